/* File: sim/cecr_bus_nodes.sv */
// stands in for the other nodes: each pulse is one frame outcome seen on the bus
module cecr_bus_nodes (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [2:0] kind_i,
    input wire logic [8:0] count_i,
    input wire logic slow_i,
    output cecr_pkg::cecr_evt_t evt_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] left;
    logic [2:0] kind;
    logic slow;
    logic gap;
    // one outcome per cycle, or every other cycle when slow to mimic long frames
    always_ff @(posedge clk_i) begin
        evt_o <= '0;
        if (rst_i) begin
            left <= 9'h000;
            gap <= 1'b0;
        end else if (start_i) begin
            left <= count_i;
            kind <= kind_i;
            slow <= slow_i;
            gap <= 1'b0;
        end else if (left != 9'h000) begin
            if (gap) begin
                gap <= 1'b0;
            end else begin
                evt_o <= cecr_pkg::cecr_evt_t'(5'h01 << kind); // rec_seq is one 11-recessive run
                left <= left - 9'h001;
                gap <= slow;
            end
        end
    end
    assign busy_o = (left != 9'h000) || start_i;
endmodule

/* File: sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] TXE = 3'h4, RXE = 3'h3, TXOK = 3'h2, RXOK = 3'h1, SEQ = 3'h0;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, start = 1'b0, slow = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [2:0] kind = 3'h0;
    logic [8:0] count = 9'h000;
    cecr_pkg::cecr_evt_t evt;
    logic irq, busoff, ext_id, busy;
    logic [1:0] opmode;
    int err_count = 0, check_count = 0;
    cecr_top cecr_top_i (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
        .rdata_o(rdata), .evt_i(evt), .irq_o(irq), .busoff_o(busoff), .opmode_o(opmode), .ext_id_o(ext_id));
    cecr_bus_nodes cecr_bus_nodes_i (.clk_i(clk), .rst_i(rst), .start_i(start), .kind_i(kind), .count_i(count),
        .slow_i(slow), .evt_o(evt), .busy_o(busy));
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    task final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // one write strobe, then an idle cycle so no strobe is assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    // read data stands only in the cycle after the strobe, so sample it mid-cycle
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(name, exp, rdata);
        @(posedge clk);
    endtask
    // hand a burst of outcomes to the bus model, wait until the last is consumed
    task automatic run(input logic [2:0] k, input logic [8:0] n, input logic s);
        kind <= k;
        count <= n;
        slow <= s;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) begin
            @(posedge clk);
        end
        @(posedge clk);
        @(posedge clk);
    endtask
    // limit far above the roughly 1220 cycles the tests need
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000004);
        @(negedge clk);
        chk("opmode_o", 32'h00000001, {30'h0, opmode});
        chk("irq_o", 32'h00000000, {31'h0, irq});
        @(posedge clk);
        $display("test reset done");
        wr(cecr_pkg::ADDR_IRQ_EN, 32'h0000000F);
        rchk("irq_en", cecr_pkg::ADDR_IRQ_EN, 32'h0000000F);
        wr(cecr_pkg::ADDR_ID_CFG, 32'h00000001);
        rchk("id_cfg", cecr_pkg::ADDR_ID_CFG, 32'h00000001);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000000);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000000);
        wr(cecr_pkg::ADDR_IRQ_EN, 32'h00000000);
        rchk("irq_en", cecr_pkg::ADDR_IRQ_EN, 32'h0000000F);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000010);
        rchk("ctrl", cecr_pkg::ADDR_CTRL, 32'h00000000);
        @(negedge clk);
        chk("ext_id_o", 32'h00000001, {31'h0, ext_id});
        @(posedge clk);
        $display("test registers done");
        run(RXE, 9'd96, 1'b0);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000002);
        @(negedge clk);
        chk("irq_o", 32'h00000001, {31'h0, irq});
        @(posedge clk);
        run(RXE, 9'd32, 1'b0);
        rchk("err_cnt", cecr_pkg::ADDR_ERR_CNT, 32'h00000080);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000006);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000001);
        wr(cecr_pkg::ADDR_IRQ_SRC, 32'hFFFFFFFB);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000002);
        wr(cecr_pkg::ADDR_IRQ_SRC, 32'hFFFFFFFD);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000000);
        @(negedge clk);
        chk("irq_o", 32'h00000000, {31'h0, irq});
        @(posedge clk);
        run(RXOK, 9'd1, 1'b0);
        rchk("err_cnt", cecr_pkg::ADDR_ERR_CNT, 32'h00000077);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000000);
        run(RXOK, 9'd119, 1'b0);
        rchk("err_cnt", cecr_pkg::ADDR_ERR_CNT, 32'h00000000);
        $display("test receive errors done");
        run(TXE, 9'd32, 1'b0);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h0000000E);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000002);
        rchk("err_cnt", cecr_pkg::ADDR_ERR_CNT, 32'h00010000);
        @(negedge clk);
        chk("busoff_o", 32'h00000001, {31'h0, busoff});
        @(posedge clk);
        run(SEQ, 9'd127, 1'b1);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000002);
        run(SEQ, 9'd1, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000000);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h0000000F);
        rchk("err_cnt", cecr_pkg::ADDR_ERR_CNT, 32'h00000000);
        wr(cecr_pkg::ADDR_IRQ_SRC, 32'h00000000);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000000);
        $display("test recovery done");
        run(TXE, 9'd32, 1'b0);
        wr(cecr_pkg::ADDR_IRQ_SRC, 32'h00000000);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000010);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000000);
        rchk("irq_src", cecr_pkg::ADDR_IRQ_SRC, 32'h00000000);
        rchk("ctrl", cecr_pkg::ADDR_CTRL, 32'h00000000);
        $display("test forced return done");
        wr(cecr_pkg::ADDR_CTRL, 32'h00000001);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000004);
        rchk("ctrl", cecr_pkg::ADDR_CTRL, 32'h00000004);
        run(TXE, 9'd32, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h0000000A);
        run(SEQ, 9'd128, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000008);
        $display("test halt at entry done");
        wr(cecr_pkg::ADDR_CTRL, 32'h00000001);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000008);
        run(TXE, 9'd32, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000002);
        run(SEQ, 9'd128, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000008);
        $display("test halt at end done");
        wr(cecr_pkg::ADDR_CTRL, 32'h00000001);
        wr(cecr_pkg::ADDR_CTRL, 32'h0000000C);
        run(TXE, 9'd32, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000002);
        wr(cecr_pkg::ADDR_CTRL, 32'h00000002);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h0000000A);
        rchk("ctrl", cecr_pkg::ADDR_CTRL, 32'h0000000E);
        run(SEQ, 9'd128, 1'b0);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000008);
        $display("test program halt done");
        // second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk("status", cecr_pkg::ADDR_STATUS, 32'h00000004);
        rchk("irq_en", cecr_pkg::ADDR_IRQ_EN, 32'h00000000);
        @(negedge clk);
        chk("busoff_o", 32'h00000000, {31'h0, busoff});
        chk("irq_o", 32'h00000000, {31'h0, irq});
        @(posedge clk);
        $display("test mid-run reset done");
        final_report();
    end
endmodule

/* File: verilog/cecr_pkg.sv */
package cecr_pkg;
    // register byte addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
    localparam logic [7:0] ADDR_IRQ_SRC = 8'h0C;
    localparam logic [7:0] ADDR_ERR_CNT = 8'h10;
    localparam logic [7:0] ADDR_ID_CFG = 8'h14;
    // control register fields
    localparam int CTRL_OPMODE_LSB = 0;
    localparam int CTRL_BOM_LSB = 2;
    localparam int CTRL_FRC_BIT = 4;
    // operating modes
    localparam logic [1:0] OPM_OPERATE = 2'h0;
    localparam logic [1:0] OPM_RESET = 2'h1;
    localparam logic [1:0] OPM_HALT = 2'h2;
    // recovery policies
    localparam logic [1:0] BOM_NORMAL = 2'h0;
    localparam logic [1:0] BOM_HALT_ENTRY = 2'h1;
    localparam logic [1:0] BOM_HALT_END = 2'h2;
    localparam logic [1:0] BOM_PROGRAM = 2'h3;
    // interrupt source bit positions
    localparam int SRC_BOR = 0;
    localparam int SRC_WARN = 1;
    localparam int SRC_PASS = 2;
    localparam int SRC_BOE = 3;
    localparam int SRC_W = 4;
    // status bit positions
    localparam int ST_PASS = 0;
    localparam int ST_BOFF = 1;
    localparam int ST_OPM_LSB = 2;
    // thresholds and recovery counts
    localparam logic [8:0] LIM_WARN = 9'h060;
    localparam logic [8:0] LIM_PASS = 9'h080;
    localparam logic [8:0] LIM_BOFF = 9'h100;
    localparam logic [7:0] RECOV_SEQ = 8'h80;
    localparam int ID_STD_W = 11;
    localparam int ID_EXT_W = 29;
    localparam logic [1:0] RST_OPMODE = 2'h1;
    typedef enum logic [2:0] {
        CECR_ACTIVE = 3'b001,
        CECR_PASSIVE = 3'b010,
        CECR_BUSOFF = 3'b100
    } cecr_state_t;
    // error, success and recessive-sequence events from the protocol engine
    typedef struct packed {
        logic tx_err;
        logic rx_err;
        logic tx_ok;
        logic rx_ok;
        logic rec_seq;
    } cecr_evt_t;
endpackage

/* File: verilog/cecr_top.sv */
// Behaviour
// R1: frame error raises transmit counter when sending, receive counter when receiving.
// R2: either counter at 96 or more sets the warning flag.
// R3: either counter at 128 or more enters error-passive and sets passive flag.
// R4: transmit counter at 256 or more enters bus-off and sets entry flag.
// R5: interrupt only for enabled sources; sources readable in source register.
// R6: software writes the interrupt enable register only in reset mode.
// R7: status register shows error-passive and bus-off bits.
// R8: source flag clears on written 0, holds on written 1.
// R9: mode 00b leaves bus-off after 128 recessive sequences into error-active.
// R10: recovery by recessive sequences sets the recovery flag.
// R11: forced return leaves the recovery flag at 0.
// R12: mode 00b forced-return bit moves bus-off straight to error-active.
// R13: forced-return bit only set in bus-off; hardware clears it itself.
// R14: mode 01b enters halt as bus-off begins.
// R15: mode 10b enters halt after returning from bus-off.
// R16: mode 11b halts when halt is requested in bus-off, else as 00b (here the forced-return bit does nothing in 11b; only 00b honours it).
// R17: software changes recovery mode only in reset mode.
// R18: software reads status to confirm an operating mode change.
// R19: standard 11-bit and extended 29-bit identifier formats supported.
// R20: counters decrement on success; passive returns active below 128.
//
// The address-and-strobe port and the address map are this design's own decisions.
module cecr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire cecr_pkg::cecr_evt_t evt_i,
    output logic irq_o,
    output logic busoff_o,
    output logic [1:0] opmode_o,
    output logic ext_id_o
);
    cecr_pkg::cecr_state_t state, next_state;
    logic [8:0] tec, next_tec;
    logic [7:0] rec, next_rec;
    logic [7:0] seq_cnt, next_seq_cnt;
    logic [1:0] operating_mode_field, next_operating_mode_field;
    logic [1:0] busoff_recovery_mode, next_busoff_recovery_mode;
    logic forced_return_bit, next_forced_return_bit;
    logic [cecr_pkg::SRC_W-1:0] error_irq_enable_reg, next_error_irq_enable_reg;
    logic [cecr_pkg::SRC_W-1:0] error_irq_source_reg, next_error_irq_source_reg;
    logic ext_id, next_ext_id;
    logic [31:0] rdata, next_rdata;
    logic [cecr_pkg::SRC_W-1:0] evt_set;
    logic [31:0] controller_status_reg;
    logic passive_status_bit;
    logic busoff_status_bit;
    logic in_reset_mode;
    logic recov_done;
    logic forced_ret;
    logic warn_lvl;
    logic pass_lvl;
    logic warn_q;

    assign in_reset_mode = (operating_mode_field == cecr_pkg::OPM_RESET);
    // status bits straight from state so polling sees the live error state
    assign passive_status_bit = (state == cecr_pkg::CECR_PASSIVE); // [R7]
    assign busoff_status_bit = (state == cecr_pkg::CECR_BUSOFF); // [R7]
    assign controller_status_reg = {28'h0000000, operating_mode_field, busoff_status_bit, passive_status_bit};
    assign warn_lvl = (tec >= cecr_pkg::LIM_WARN) || ({1'b0, rec} >= cecr_pkg::LIM_WARN); // [R2]
    assign pass_lvl = (tec >= cecr_pkg::LIM_PASS) || ({1'b0, rec} >= cecr_pkg::LIM_PASS); // [R3]
    assign recov_done = busoff_status_bit && evt_i.rec_seq && (seq_cnt == cecr_pkg::RECOV_SEQ - 8'h01); // [R9]
    assign forced_ret = busoff_status_bit && forced_return_bit && (busoff_recovery_mode == cecr_pkg::BOM_NORMAL);

    // error counters, fault state and recovery sequence count
    always_comb begin
        next_tec = tec;
        next_rec = rec;
        next_state = state;
        next_seq_cnt = seq_cnt;
        evt_set = '0;
        case (state)
            cecr_pkg::CECR_ACTIVE, cecr_pkg::CECR_PASSIVE: begin
                // saturating: a counter never wraps back below a threshold
                if (evt_i.tx_err && tec < cecr_pkg::LIM_BOFF) begin
                    next_tec = tec + 9'h008; // [R1]
                end else if (evt_i.tx_ok && tec != 9'h000) begin
                    next_tec = tec - 9'h001; // [R20]
                end
                if (evt_i.rx_err && rec != 8'hFF) begin
                    next_rec = rec + 8'h01; // [R1]
                end else if (evt_i.rx_ok && rec != 8'h00) begin
                    next_rec = (rec > 8'h7F) ? 8'h77 : rec - 8'h01; // [R20]
                end
                if (next_tec >= cecr_pkg::LIM_BOFF) begin
                    next_state = cecr_pkg::CECR_BUSOFF; // [R4]
                    next_seq_cnt = 8'h00;
                    evt_set[cecr_pkg::SRC_BOE] = 1'b1; // [R4]
                end else if (next_tec >= cecr_pkg::LIM_PASS || {1'b0, next_rec} >= cecr_pkg::LIM_PASS) begin
                    next_state = cecr_pkg::CECR_PASSIVE; // [R3]
                    evt_set[cecr_pkg::SRC_PASS] = (state == cecr_pkg::CECR_ACTIVE); // [R3]
                end else begin
                    next_state = cecr_pkg::CECR_ACTIVE; // [R20]
                end
            end
            cecr_pkg::CECR_BUSOFF: begin
                if (forced_ret) begin
                    next_state = cecr_pkg::CECR_ACTIVE; // [R12] [R11]
                    next_tec = 9'h000;
                    next_rec = 8'h00;
                end else if (recov_done) begin
                    next_state = cecr_pkg::CECR_ACTIVE; // [R9] [R16]
                    next_tec = 9'h000;
                    next_rec = 8'h00;
                    evt_set[cecr_pkg::SRC_BOR] = 1'b1; // [R10]
                end else if (evt_i.rec_seq) begin
                    next_seq_cnt = seq_cnt + 8'h01;
                end
            end
            default: begin
                next_state = cecr_pkg::CECR_ACTIVE;
            end
        endcase
        // warning fires on the rising crossing of 96
        evt_set[cecr_pkg::SRC_WARN] = warn_lvl && !warn_q; // [R2]
    end

    // software registers with hardware side effects
    always_comb begin
        next_operating_mode_field = operating_mode_field;
        next_busoff_recovery_mode = busoff_recovery_mode;
        next_forced_return_bit = 1'b0; // [R13]
        next_error_irq_enable_reg = error_irq_enable_reg;
        next_ext_id = ext_id;
        next_rdata = 32'h00000000;
        if (wr_i && addr_i == cecr_pkg::ADDR_CTRL) begin
            next_operating_mode_field = wdata_i[cecr_pkg::CTRL_OPMODE_LSB +: 2];
            // recovery policy is only taken in reset mode
            if (in_reset_mode) begin
                next_busoff_recovery_mode = wdata_i[cecr_pkg::CTRL_BOM_LSB +: 2]; // [R17]
            end
            // forced return only meaningful while in bus-off
            next_forced_return_bit = wdata_i[cecr_pkg::CTRL_FRC_BIT] && busoff_status_bit; // [R13]
        end
        if (wr_i && addr_i == cecr_pkg::ADDR_IRQ_EN && in_reset_mode) begin
            next_error_irq_enable_reg = wdata_i[cecr_pkg::SRC_W-1:0]; // [R6]
        end
        if (wr_i && addr_i == cecr_pkg::ADDR_ID_CFG) begin
            next_ext_id = wdata_i[0]; // [R19]
        end
        // automatic halt entry per recovery policy
        if (evt_set[cecr_pkg::SRC_BOE] && busoff_recovery_mode == cecr_pkg::BOM_HALT_ENTRY) begin
            next_operating_mode_field = cecr_pkg::OPM_HALT; // [R14]
        end
        if (busoff_status_bit && (forced_ret || recov_done) && busoff_recovery_mode == cecr_pkg::BOM_HALT_END) begin
            next_operating_mode_field = cecr_pkg::OPM_HALT; // [R15]
        end
        if (rd_i) begin
            case (addr_i)
                cecr_pkg::ADDR_CTRL: next_rdata = {27'h0000000, forced_return_bit, busoff_recovery_mode,
                    operating_mode_field};
                cecr_pkg::ADDR_STATUS: next_rdata = controller_status_reg; // [R18]
                cecr_pkg::ADDR_IRQ_EN: next_rdata = {28'h0000000, error_irq_enable_reg};
                cecr_pkg::ADDR_IRQ_SRC: next_rdata = {28'h0000000, error_irq_source_reg}; // [R5]
                cecr_pkg::ADDR_ERR_CNT: next_rdata = {15'h0000, tec, rec};
                cecr_pkg::ADDR_ID_CFG: next_rdata = {31'h00000000, ext_id};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // source flags: written 0 clears, 1 holds; a new event beats the clear
    always_comb begin
        next_error_irq_source_reg = error_irq_source_reg;
        if (wr_i && addr_i == cecr_pkg::ADDR_IRQ_SRC) begin
            next_error_irq_source_reg = error_irq_source_reg & wdata_i[cecr_pkg::SRC_W-1:0]; // [R8]
        end
        next_error_irq_source_reg = next_error_irq_source_reg | evt_set; // [R5]
    end

    // register all state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= cecr_pkg::CECR_ACTIVE;
            tec <= 9'h000;
            rec <= 8'h00;
            seq_cnt <= 8'h00;
            warn_q <= 1'b0;
            operating_mode_field <= cecr_pkg::RST_OPMODE;
            busoff_recovery_mode <= cecr_pkg::BOM_NORMAL;
            forced_return_bit <= 1'b0;
            error_irq_enable_reg <= '0;
            error_irq_source_reg <= '0;
            ext_id <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            state <= next_state;
            tec <= next_tec;
            rec <= next_rec;
            seq_cnt <= next_seq_cnt;
            warn_q <= warn_lvl;
            operating_mode_field <= next_operating_mode_field;
            busoff_recovery_mode <= next_busoff_recovery_mode;
            forced_return_bit <= next_forced_return_bit;
            error_irq_enable_reg <= next_error_irq_enable_reg;
            error_irq_source_reg <= next_error_irq_source_reg;
            ext_id <= next_ext_id;
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;
    assign irq_o = |(error_irq_source_reg & error_irq_enable_reg); // [R5]
    assign busoff_o = busoff_status_bit;
    assign opmode_o = operating_mode_field;
    assign ext_id_o = ext_id;

    // checks
    property p_boff_entry;
        @(posedge clk_i) disable iff (rst_i)
        (!busoff_status_bit && evt_i.tx_err && tec >= 9'h0F8) |=> busoff_status_bit && error_irq_source_reg[3];
    endproperty
    a_boff_entry: assert property (p_boff_entry) else $error("bus-off entry missed"); // [R4]
    property p_passive;
        @(posedge clk_i) disable iff (rst_i)
        (pass_lvl && state != cecr_pkg::CECR_BUSOFF) |-> state == cecr_pkg::CECR_PASSIVE;
    endproperty
    a_passive: assert property (p_passive) else $error("active at passive level"); // [R3]
    property p_warn;
        @(posedge clk_i) disable iff (rst_i)
        $rose(warn_lvl) |=> error_irq_source_reg[1];
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag not set"); // [R2]
    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == cecr_pkg::ADDR_IRQ_EN && !in_reset_mode) |=> $stable(error_irq_enable_reg);
    endproperty
    a_irq: assert property (p_irq) else $error("enable changed outside reset mode"); // [R6]
    property p_recov;
        @(posedge clk_i) disable iff (rst_i)
        recov_done && !forced_ret |=> state == cecr_pkg::CECR_ACTIVE && error_irq_source_reg[0];
    endproperty
    a_recov: assert property (p_recov) else $error("recovery wrong"); // [R9] [R10]
    property p_forced;
        @(posedge clk_i) disable iff (rst_i)
        forced_ret && !error_irq_source_reg[0] |=> !error_irq_source_reg[0] && !busoff_status_bit;
    endproperty
    a_forced: assert property (p_forced) else $error("forced return wrong"); // [R11] [R12]
    property p_frc_clear;
        @(posedge clk_i) disable iff (rst_i)
        forced_return_bit |=> !forced_return_bit;
    endproperty
    a_frc_clear: assert property (p_frc_clear) else $error("forced bit stuck"); // [R13]
    property p_halt_entry;
        @(posedge clk_i) disable iff (rst_i)
        $rose(busoff_status_bit) && busoff_recovery_mode == 2'h1 |-> operating_mode_field == 2'h2;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("no halt at bus-off"); // [R14]
    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        wr_i && addr_i == 8'h0C && !wdata_i[2] && evt_set[2] == 1'b0 |=> !error_irq_source_reg[2];
    endproperty
    a_clear: assert property (p_clear) else $error("source flag not cleared"); // [R8]
    c_boff: cover property (@(posedge clk_i) disable iff (rst_i) $rose(busoff_status_bit));
    c_recov: cover property (@(posedge clk_i) disable iff (rst_i) recov_done);
    c_forced: cover property (@(posedge clk_i) disable iff (rst_i) forced_ret);
endmodule
